// ### verilog/aqx_pkg.sv
// package: offsets, reset values and timing constants of the aux register bank
package aqx_pkg;
    localparam logic [7:0] AQX_IDX_FRAME_COUNT = 8'h30;
    localparam logic [7:0] AQX_IDX_AUX_ROUTING = 8'hD0;
    localparam logic [7:0] AQX_IDX_FIFO_WAITING = 8'hE0;
    localparam logic [7:0] AQX_IDX_FIFO_CONFIG = 8'hE4;
    localparam logic [7:0] AQX_IDX_SCRATCH = 8'hF8;
    localparam logic [31:0] AQX_FRAME_COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] AQX_FIFO_WAITING_RST = 32'h0000_0000;
    localparam logic [15:0] AQX_SCRATCH_RST = 16'h0000;
    localparam logic [7:0] AQX_ROUTING_RST = 8'h00;
    localparam logic AQX_PREFETCH_RST = 1'b0;
    // routing byte and FIFO config byte field positions
    localparam int AQX_A_SEL_LSB = 0;
    localparam int AQX_A_PE_BIT = 3;
    localparam int AQX_B_SEL_LSB = 4;
    localparam int AQX_B_PE_BIT = 7;
    localparam int AQX_PREFETCH_BIT = 7;
    // pulse stretch time and its cycle count at 125 MHz
    localparam int AQX_CLK_PERIOD_PS = 8000;
    localparam int AQX_STRETCH_NS = 100;
    localparam int AQX_STRETCH_CYCLES = (AQX_STRETCH_NS * 1000) / AQX_CLK_PERIOD_PS;
    localparam int AQX_STRETCH_W = 5;
    // classic wait-state length for a sample read from main memory
    localparam int AQX_WAIT_CYCLES = 4;
    localparam int AQX_WAIT_W = 3;
    typedef enum logic [1:0] {
        AQX_RD_IDLE = 2'b00,
        AQX_RD_WAIT = 2'b01,
        AQX_RD_DONE = 2'b10
    } aqx_rd_state_e;
endpackage

// ### verilog/aqx_stretch.sv
// pulse stretcher for one auxiliary output
`timescale 1ns/1ps
module aqx_stretch
    import aqx_pkg::*;
#(
    parameter int STRETCH_CYCLES = AQX_STRETCH_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic sig_in,
    output logic sig_out
);
    logic [AQX_STRETCH_W-1:0] hold_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_reg <= '0;
        end else if (sig_in) begin
            hold_reg <= AQX_STRETCH_W'(STRETCH_CYCLES);
        end else if (hold_reg != '0) begin
            hold_reg <= hold_reg - 1'b1;
        end
    end
    // registered so the pin never glitches on mux changes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sig_out <= 1'b0;
        end else begin
            sig_out <= sig_in | (enable & (hold_reg != '0));
        end
    end
endmodule

// ### verilog/aqx_aux_bank.sv
// extended indexed register bank: counters, aux output routing, prefetch, scratch
//
// Behaviour
// - read-only 32-bit counter: samples when not bursting, frames in burst mode.
// - counter resets to zero; host writes do not change it.
// - aux output b driven by 3-bit source selector, code 000 default.
// - aux output a driven by 3-bit source selector, code 000 default.
// - b stretch enable lengthens output b by about 100 ns; resets off.
// - a stretch enable lengthens output a by about 100 ns; resets off.
// - read-only 32-bit count of sample words queued in FIFO, resets zero.
// - top bit of FIFO config byte routes sample reads through prefetch buffer.
// - prefetch off keeps classic wait states; on avoids all of them.
// - 16-bit scratch register, resets zero, each byte reads back its last write.
// - bank select needed; odd index is upper byte of preceding even word.
// - counter reaching programmed frame limit raises an event output.
`timescale 1ns/1ps
module aqx_aux_bank
    import aqx_pkg::*;
#(
    parameter int WAIT_CYCLES = AQX_WAIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic bank_select,
    input wire logic [7:0] host_index,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_word,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    input wire logic sample_rd_req,
    output logic sample_rd_ready,
    output logic sample_from_prefetch,
    input wire logic burst_mode,
    input wire logic sample_strobe,
    input wire logic frame_done,
    input wire logic sample_queued,
    input wire logic [31:0] frame_limit_value,
    output logic frame_limit_hit,
    input wire logic timer_ch0_out,
    input wire logic timer_ch2_out,
    input wire logic digital_output_bit_four,
    input wire logic digital_output_bit_five,
    input wire logic trig_delay_end,
    input wire logic trig_delay_start,
    input wire logic irq_threshold_max,
    input wire logic sampling_active,
    input wire logic sample_hi_decode,
    input wire logic irq_line,
    input wire logic frame_timer,
    input wire logic irq_count_inc,
    input wire logic bus_ready,
    output logic aux_output_a,
    output logic aux_output_b
);
    import aqx_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // async pin sources pass two flops; on-chip strobes enter directly
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {timer_ch0_out, timer_ch2_out, digital_output_bit_four,
                           digital_output_bit_five, bus_ready};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // host access decode
    // ------------------------------------------------------------
    logic acc_wr;
    logic acc_rd;
    logic [7:0] word_index;
    assign acc_wr = host_wr & bank_select;
    assign acc_rd = host_rd & bank_select;
    assign word_index = {host_index[7:1], 1'b0};

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] base,
                                 input int nbytes);
        return (idx >= base) && ({24'h000000, idx} < ({24'h000000, base} + 32'(nbytes)));
    endfunction

    // merge a write into a 16-bit word lane, honouring byte or word access
    function automatic logic [15:0] merge16(input logic [15:0] cur,
                                            input logic [15:0] wd,
                                            input logic odd, input logic word);
        logic [15:0] res;
        res = cur;
        if (word) begin
            res = wd;
        end else if (odd) begin
            res[15:8] = wd[7:0];
        end else begin
            res[7:0] = wd[7:0];
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // frame / sample counter
    // ------------------------------------------------------------
    logic [31:0] frame_count_reg;
    logic count_evt;
    assign count_evt = burst_mode ? frame_done : sample_strobe;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            frame_count_reg <= AQX_FRAME_COUNT_RST;
        end else if (count_evt) begin
            frame_count_reg <= frame_count_reg + 32'h0000_0001;
        end
    end

    // one-cycle event as the counter arrives at the limit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            frame_limit_hit <= 1'b0;
        end else begin
            frame_limit_hit <= count_evt &&
                (frame_count_reg + 32'h0000_0001 == frame_limit_value);
        end
    end

    // ------------------------------------------------------------
    // fifo words waiting
    // ------------------------------------------------------------
    logic [31:0] fifo_words_waiting_reg;
    logic fifo_pop;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fifo_words_waiting_reg <= AQX_FIFO_WAITING_RST;
        end else begin
            unique case ({sample_queued, fifo_pop})
                2'b10: fifo_words_waiting_reg <= fifo_words_waiting_reg + 32'h0000_0001;
                2'b01: fifo_words_waiting_reg <= fifo_words_waiting_reg - 32'h0000_0001;
                2'b00, 2'b11: fifo_words_waiting_reg <= fifo_words_waiting_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    logic [7:0] aux_routing_reg;
    logic prefetch_buffer_en;
    logic [15:0] scratch_word_reg;
    logic [15:0] routing_m;
    assign routing_m = merge16({8'h00, aux_routing_reg}, host_wdata, host_index[0], host_word);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aux_routing_reg <= AQX_ROUTING_RST;
        end else if (acc_wr && word_index == AQX_IDX_AUX_ROUTING) begin
            aux_routing_reg <= routing_m[7:0];
        end
    end

    // config is a single byte at its even index; the upper bits are don't care
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prefetch_buffer_en <= AQX_PREFETCH_RST;
        end else if (acc_wr && host_index == AQX_IDX_FIFO_CONFIG) begin
            prefetch_buffer_en <= host_wdata[AQX_PREFETCH_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scratch_word_reg <= AQX_SCRATCH_RST;
        end else if (acc_wr && word_index == AQX_IDX_SCRATCH) begin
            scratch_word_reg <= merge16(scratch_word_reg, host_wdata,
                                        host_index[0], host_word);
        end
    end

    // ------------------------------------------------------------
    // read-back
    // ------------------------------------------------------------
    logic [15:0] rd_word;
    always_comb begin
        rd_word = 16'h0000;
        if (hit(word_index, AQX_IDX_FRAME_COUNT, 4)) begin
            rd_word = word_index[1] ? frame_count_reg[31:16] : frame_count_reg[15:0];
        end else if (word_index == AQX_IDX_AUX_ROUTING) begin
            rd_word = {8'h00, aux_routing_reg};
        end else if (hit(word_index, AQX_IDX_FIFO_WAITING, 4)) begin
            rd_word = word_index[1] ? fifo_words_waiting_reg[31:16]
                                    : fifo_words_waiting_reg[15:0];
        end else if (word_index == AQX_IDX_FIFO_CONFIG) begin
            rd_word = {8'h00, prefetch_buffer_en, 7'h00};
        end else if (word_index == AQX_IDX_SCRATCH) begin
            rd_word = scratch_word_reg;
        end
    end

    // unmapped reads return zero; bank-off reads leave the read data unchanged
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_rdata <= 16'h0000;
        end else if (acc_rd) begin
            if (host_word) begin
                host_rdata <= rd_word;
            end else begin
                host_rdata <= {8'h00, host_index[0] ? rd_word[15:8] : rd_word[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // sample read timing
    // ------------------------------------------------------------
    // prefetch answers next cycle; main memory path holds ready low
    aqx_rd_state_e rd_state_reg;
    logic [AQX_WAIT_W-1:0] wait_cnt_reg;
    assign fifo_pop = (rd_state_reg == AQX_RD_DONE);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_state_reg <= AQX_RD_IDLE;
            wait_cnt_reg <= '0;
            sample_rd_ready <= 1'b1;
            sample_from_prefetch <= 1'b0;
        end else begin
            unique case (rd_state_reg)
                AQX_RD_IDLE: begin
                    if (sample_rd_req) begin
                        sample_from_prefetch <= prefetch_buffer_en;
                        if (prefetch_buffer_en) begin
                            rd_state_reg <= AQX_RD_DONE;
                        end else begin
                            sample_rd_ready <= 1'b0;
                            wait_cnt_reg <= AQX_WAIT_W'(WAIT_CYCLES - 1);
                            rd_state_reg <= AQX_RD_WAIT;
                        end
                    end
                end
                AQX_RD_WAIT: begin
                    if (wait_cnt_reg == '0) begin
                        sample_rd_ready <= 1'b1;
                        rd_state_reg <= AQX_RD_DONE;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg - 1'b1;
                    end
                end
                AQX_RD_DONE: begin
                    rd_state_reg <= AQX_RD_IDLE;
                end
                default: begin
                    rd_state_reg <= AQX_RD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // aux output routing
    // ------------------------------------------------------------
    logic src_a;
    logic src_b;
    always_comb begin
        unique case (aux_routing_reg[AQX_A_SEL_LSB +: 3])
            3'h0: src_a = pin_s2_reg[4];
            3'h1: src_a = pin_s2_reg[2];
            3'h2: src_a = trig_delay_end;
            3'h3: src_a = trig_delay_start;
            3'h4: src_a = irq_threshold_max;
            3'h5: src_a = sampling_active;
            3'h6: src_a = sample_hi_decode;
            3'h7: src_a = irq_line;
        endcase
    end
    always_comb begin
        unique case (aux_routing_reg[AQX_B_SEL_LSB +: 3])
            3'h0: src_b = pin_s2_reg[3];
            3'h1: src_b = pin_s2_reg[1];
            3'h2: src_b = sample_strobe;
            3'h3: src_b = sampling_active;
            3'h4: src_b = frame_timer;
            3'h5: src_b = irq_count_inc;
            3'h6: src_b = 1'b0;
            3'h7: src_b = pin_s2_reg[0];
        endcase
    end

    aqx_stretch #(
        .STRETCH_CYCLES(AQX_STRETCH_CYCLES)
    ) u_stretch_a (
        .clk(clk),
        .reset(reset),
        .enable(aux_routing_reg[AQX_A_PE_BIT]),
        .sig_in(src_a),
        .sig_out(aux_output_a)
    );

    aqx_stretch #(
        .STRETCH_CYCLES(AQX_STRETCH_CYCLES)
    ) u_stretch_b (
        .clk(clk),
        .reset(reset),
        .enable(aux_routing_reg[AQX_B_PE_BIT]),
        .sig_in(src_b),
        .sig_out(aux_output_b)
    );
endmodule

// ### test/aqx_aux_bank_props.sv
// checker: bus, sample read, frame limit and pulse stretch properties
`timescale 1ns/1ps
module aqx_aux_bank_props
    import aqx_pkg::*;
#(
    parameter int WAIT_CYCLES = AQX_WAIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic bank_select,
    input wire logic [7:0] host_index,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_word,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic sample_rd_req,
    input wire logic sample_rd_ready,
    input wire logic sample_from_prefetch,
    input wire logic burst_mode,
    input wire logic sample_strobe,
    input wire logic frame_done,
    input wire logic [31:0] frame_limit_value,
    input wire logic frame_limit_hit,
    input wire logic aux_output_a,
    input wire logic aux_output_b
);
    logic [31:0] cnt_sh;
    logic [7:0] rt_sh;
    logic pf_sh;
    logic [2:0] cfg_age;
    logic [3:0] lo_run;
    logic ev;
    logic rt_wr;
    assign ev = burst_mode ? frame_done : sample_strobe;
    assign rt_wr = host_wr && bank_select && host_index == AQX_IDX_AUX_ROUTING;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_sh <= AQX_FRAME_COUNT_RST;
            lo_run <= 4'h0;
        end else begin
            cnt_sh <= cnt_sh + 32'(ev);
            lo_run <= sample_rd_ready ? 4'h0 : lo_run + 4'h1;
        end
    end
    // config is not a port, so it is shadowed from accepted bus writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rt_sh <= AQX_ROUTING_RST;
            pf_sh <= AQX_PREFETCH_RST;
            cfg_age <= 3'h0;
        end else begin
            if (rt_wr) begin
                rt_sh <= host_wdata[7:0];
            end
            if (host_wr && bank_select && host_index == AQX_IDX_FIFO_CONFIG) begin
                pf_sh <= host_wdata[AQX_PREFETCH_BIT];
            end
            cfg_age <= rt_wr ? 3'h0 : cfg_age + 3'(cfg_age != 3'h7);
        end
    end
    rdata_hold_a: assert property (!(host_rd && bank_select) |=> $stable(host_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (host_rd && bank_select &&
        !(host_index[7:4] inside {4'h3, 4'hD, 4'hE, 4'hF}) |=> host_rdata == 16'h0000)
        else $error("unmapped index read not zero");
    count_read_a: assert property (host_rd && bank_select && host_word &&
        host_index == AQX_IDX_FRAME_COUNT |=> host_rdata == $past(cnt_sh[15:0]))
        else $error("frame count read wrong");
    limit_hit_a: assert property (frame_limit_hit ==
        $past(ev && cnt_sh + 32'h1 == frame_limit_value))
        else $error("frame limit pulse wrong");
    classic_wait_a: assert property (sample_rd_req && !pf_sh |=>
        !sample_rd_ready [*4] ##[1:2] sample_rd_ready)
        else $error("classic wait states wrong");
    prefetch_fast_a: assert property (sample_rd_req && pf_sh |=> sample_rd_ready [*3])
        else $error("prefetch read stalled");
    prefetch_flag_a: assert property (sample_rd_req |=> sample_from_prefetch == $past(pf_sh))
        else $error("prefetch flag wrong");
    wait_bound_a: assert property (lo_run <= WAIT_CYCLES + 1)
        else $error("ready low too long");
    stretch_out_a: assert property (rt_sh[AQX_A_PE_BIT] && cfg_age == 3'h7 &&
        $rose(aux_output_a) |-> aux_output_a [*8])
        else $error("output a not stretched");
    b_stretch_a: assert property (rt_sh[AQX_B_PE_BIT] && cfg_age == 3'h7 &&
        $rose(aux_output_b) |-> aux_output_b [*8])
        else $error("output b not stretched");
    cover property (sample_rd_req && !pf_sh);
    cover property (sample_rd_req && pf_sh);
    cover property (frame_limit_hit);
endmodule
bind aqx_aux_bank aqx_aux_bank_props #(.WAIT_CYCLES(WAIT_CYCLES)) aqx_aux_bank_props_i (.*);

// ### test/aqx_host_model.sv
// host processor model: indexed register cycles and sample read requests
`timescale 1ns/1ps
module aqx_host_model (
    input wire logic clk,
    output logic bank_select,
    output logic [7:0] host_index,
    output logic host_wr,
    output logic host_rd,
    output logic host_word,
    output logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    output logic sample_rd_req
);
    initial begin
        {bank_select, host_wr, host_rd, host_word, sample_rd_req} = 5'h00;
        host_index = 8'h00;
        host_wdata = 16'h0000;
    end
    // released lines show the inverse so stale values never look valid
    task automatic cyc(input logic bs, input logic [7:0] idx, input logic w, input logic r,
                       input logic wd, input logic [15:0] d);
        @(posedge clk);
        bank_select <= bs;
        host_index <= idx;
        host_word <= wd;
        host_wdata <= d;
        host_wr <= w;
        host_rd <= r;
        @(posedge clk);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        host_index <= ~idx;
        host_wdata <= ~d;
    endtask
    task automatic wr(input logic bs, input logic [7:0] idx, input logic wd, input logic [15:0] d);
        cyc(bs, idx, 1'b1, 1'b0, wd, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic wd, output logic [15:0] q);
        cyc(1'b1, idx, 1'b0, 1'b1, wd, 16'h0000);
        @(posedge clk);
        q = host_rdata;
    endtask
    task automatic sread();
        @(posedge clk);
        sample_rd_req <= 1'b1;
        @(posedge clk);
        sample_rd_req <= 1'b0;
    endtask
endmodule

// ### test/aqx_aux_bank_tb.sv
// testbench: aux register bank against a behavioural model
`timescale 1ns/1ps
module aqx_aux_bank_tb;
    import aqx_pkg::*;
    logic clk, reset, bank_select, host_wr, host_rd, host_word, sample_rd_req;
    logic sample_rd_ready, sample_from_prefetch, burst_mode, frame_done, sample_queued;
    logic frame_limit_hit, aux_output_a, aux_output_b;
    logic rchk = 1'b0;
    logic [7:0] host_index, rt;
    logic [15:0] host_wdata, host_rdata, q;
    logic [31:0] frame_limit_value, r;
    logic [31:0] seed = 32'h0001_6309;
    logic [13:0] srcs, h1, h2, h3;
    logic [7:0] ridx [7] = '{8'h30, 8'h32, 8'hD0, 8'hE0, 8'hE2, 8'hE4, 8'hF8};
    int n_errors = 0;
    int samples_checked = 0;
    int m_cnt = 0;
    int m_fifo = 0;
    wire [7:0] va = {h1[10], h1[9], h1[8], h1[7], h1[6], h1[5], h3[2], h3[0]};
    wire [7:0] vb = {h3[4], 1'b0, h1[12], h1[11], h1[8], h1[13], h3[3], h3[1]};
    aqx_aux_bank aqx_aux_bank_i (.*, .sample_strobe(srcs[13]), .timer_ch0_out(srcs[0]),
        .timer_ch2_out(srcs[1]), .digital_output_bit_four(srcs[2]),
        .digital_output_bit_five(srcs[3]), .bus_ready(srcs[4]), .trig_delay_end(srcs[5]),
        .trig_delay_start(srcs[6]), .irq_threshold_max(srcs[7]), .sampling_active(srcs[8]),
        .sample_hi_decode(srcs[9]), .irq_line(srcs[10]), .frame_timer(srcs[11]),
        .irq_count_inc(srcs[12]));
    aqx_host_model aqx_host_model_i (.*);
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // source history: same-clock sources land after one edge, pins after three
    always @(posedge clk) begin
        h1 <= srcs;
        h2 <= h1;
        h3 <= h2;
        if (!reset && (burst_mode ? frame_done : srcs[13])) m_cnt++;
        if (!reset && sample_queued) m_fifo++;
    end
    always @(negedge clk) if (rchk) begin
        chk(aux_output_a, va[rt[2:0]]);
        chk(aux_output_b, vb[rt[6:4]]);
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        {reset, burst_mode, frame_done, sample_queued} = 4'h8;
        srcs = '0;
        frame_limit_value = 32'd40;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        foreach (ridx[i]) begin
            aqx_host_model_i.rd(ridx[i], !(ridx[i] inside {8'hD0, 8'hE4}), q);
            chk(q & (ridx[i] == 8'hE4 ? 16'h0080 : 16'hFFFF), 0);
        end
        for (int i = 0; i < 4; i++) begin
            r = xs();
            aqx_host_model_i.wr(1'b1, 8'hF8, 1'b1, r[15:0]);
            aqx_host_model_i.wr(1'b1, 8'hF9, 1'b0, {8'h00, r[23:16]});
            aqx_host_model_i.wr(1'b0, 8'hF8, 1'b1, r[31:16]);
            aqx_host_model_i.rd(8'hF8, 1'b1, q);
            chk(q, {r[23:16], r[7:0]});
            aqx_host_model_i.rd(8'hF9, 1'b0, q);
            chk(q, {8'h00, r[23:16]});
        end
        aqx_host_model_i.rd(8'h40, 1'b1, q);
        chk(q, 0);
        for (int p = 0; p < 2; p++) for (int c = 0; c < 8; c++) begin
            rt = {p[0], c[2:0], p[0], c[2:0]};
            aqx_host_model_i.wr(1'b1, 8'hD0, 1'b0, {8'h00, rt});
            aqx_host_model_i.rd(8'hD0, 1'b0, q);
            chk(q, {8'h00, rt});
            // one edge between the last random value and the release below
            repeat (30) begin
                r = xs();
                srcs <= r[13:0];
                burst_mode <= r[14];
                frame_done <= r[15];
                rchk <= (p == 0);
                @(posedge clk);
            end
            rchk <= 1'b0;
            srcs <= '0;
            frame_done <= 1'b0;
            repeat (16) @(posedge clk);
        end
        aqx_host_model_i.wr(1'b1, 8'h30, 1'b1, 16'hA5A5);
        aqx_host_model_i.rd(8'h30, 1'b1, q);
        chk(q, m_cnt[15:0]);
        aqx_host_model_i.rd(8'h32, 1'b1, q);
        chk(q, m_cnt[31:16]);
        aqx_host_model_i.rd(8'h31, 1'b0, q);
        chk(q, {8'h00, m_cnt[15:8]});
        for (int p = 0; p < 2; p++) begin
            aqx_host_model_i.wr(1'b1, 8'hE4, 1'b0, {8'h00, p[0], 7'h00});
            aqx_host_model_i.rd(8'hE4, 1'b0, q);
            chk(q[7], p[0]);
            // two queued words; the first lands on the prefetch pop edge
            aqx_host_model_i.sread();
            m_fifo--;
            sample_queued <= 1'b1;
            @(posedge clk);
            chk(sample_from_prefetch, p[0]);
            @(posedge clk);
            sample_queued <= 1'b0;
            for (int k = 0; k < 20 && sample_rd_ready !== 1'b1; k++) @(posedge clk);
            chk(sample_rd_ready, 1);
            repeat (10) @(posedge clk);
        end
        aqx_host_model_i.rd(8'hE0, 1'b1, q);
        chk(q, m_fifo[15:0]);
        aqx_host_model_i.rd(8'hE2, 1'b1, q);
        chk(q, m_fifo[31:16]);
        final_report();
    end
endmodule
